// [slx_crossbar.sv]
// Purpose: Receive lane crossbar, eight physical inputs onto eight logical lanes.
// Assumes: Deserialized words arrive on clk_sys; register port is synchronous.
// Notes: One buffer per physical input; lanes sharing a source pop together.
module slx_crossbar
  import slx_pkg::*;
#(
  parameter int DATA_W = SLX_DATA_W,
  parameter int DEPTH = SLX_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  // Configuration register port
  input wire logic [SLX_ADDR_W-1:0] reg_addr,
  input wire logic [SLX_BYTE_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [SLX_BYTE_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Physical serial inputs, one word per lane per cycle
  input wire logic [SLX_LANES-1:0] phys_valid,
  input wire logic [SLX_LANES-1:0][DATA_W-1:0] phys_data,
  output logic [SLX_LANES-1:0] phys_ready,
  // Logical lanes toward the link layer
  output logic [SLX_LANES-1:0] lane_valid,
  output logic [SLX_LANES-1:0][DATA_W-1:0] lane_data,
  input wire logic [SLX_LANES-1:0] lane_ready
);

  // Selector storage, one code per logical lane
  logic [SLX_SEL_W-1:0] sel_reg [SLX_LANES];
  // Decoded access kind of the current address
  slx_reg_t acc_kind;
  // Write strobe for any selector pair
  logic wr_sel;
  // Pair index 0..3 of the addressed selector register
  logic [1:0] wr_pair;
  // Readback byte of each selector pair
  logic [SLX_BYTE_W-1:0] pair_byte [SLX_LANES/2];
  // Read multiplexer result
  logic [SLX_BYTE_W-1:0] rd_mux;
  // Read answer flops
  logic [SLX_BYTE_W-1:0] rdata_reg;
  logic rvalid_reg;

  // Buffer side signals
  logic [SLX_LANES-1:0] f_valid;
  logic [SLX_LANES-1:0] f_pop;
  logic [SLX_LANES-1:0] f_full;
  logic [SLX_LANES-1:0] f_empty;
  logic [DATA_W-1:0] f_data [SLX_LANES];
  // users[n][k]: logical lane k takes from physical input n
  logic [SLX_LANES-1:0] users [SLX_LANES];
  // Lane k output stage can take a new word this cycle
  logic [SLX_LANES-1:0] lane_open;
  // Lane k loads a new word this cycle
  logic [SLX_LANES-1:0] lane_load;
  // Word offered to lane k by its current source
  logic [DATA_W-1:0] lane_src_data [SLX_LANES];
  // Output stage flops
  logic [SLX_LANES-1:0] lane_valid_reg;
  logic [SLX_LANES-1:0] lane_valid_next;
  logic [SLX_LANES-1:0][DATA_W-1:0] lane_data_reg;

  // Register decode, shared by writes and reads
  assign acc_kind = slx_decode(reg_addr);
  // Selector kinds have the top code bit clear
  assign wr_sel = reg_wr && !acc_kind[2];
  assign wr_pair = acc_kind[1:0];

  // Selector registers, two per byte
  for (genvar k = 0; k < SLX_LANES; k++) begin : g_sel
    localparam logic [1:0] PAIR = 2'(k / 2);
    localparam int LSB = (k % 2 == 1) ? SLX_HI_LSB : SLX_LO_LSB;
    wire hit = wr_sel && (wr_pair == PAIR);
    wire [SLX_SEL_W-1:0] field = reg_wdata[LSB +: SLX_SEL_W];
    // Identity mapping out of reset, any code writable
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        sel_reg[k] <= SLX_RST_SEL[k]; // R2 R3 R4 R7
      end else if (hit) begin
        sel_reg[k] <= field; // R2 R3 R4 R7
      end
    end
  end

  // Readback bytes; reserved bits fixed at zero
  for (genvar p = 0; p < SLX_LANES / 2; p++) begin : g_pair
    assign pair_byte[p] = {SLX_RSVD_VAL, sel_reg[2*p+1], sel_reg[2*p]}; // R1
  end

  // Read selection; unmapped addresses answer zero
  assign rd_mux = !acc_kind[2] ? pair_byte[wr_pair] :
                  (acc_kind == SLX_REG_FULL) ? f_full : // R5
                  (acc_kind == SLX_REG_EMPTY) ? f_empty : // R6
                  SLX_RDATA_RST;

  // Read answer one cycle after the strobe
  // Status is sampled, never cleared, so reads disturb nothing
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= SLX_RDATA_RST;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) rdata_reg <= rd_mux; // R8
    end
  end

  // One buffer behind each physical input
  for (genvar n = 0; n < SLX_LANES; n++) begin : g_fifo
    slx_fifo #(
      .W(DATA_W),
      .DEPTH(DEPTH)
    ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(phys_valid[n]),
      .in_ready(phys_ready[n]),
      .in_data(phys_data[n]),
      .out_valid(f_valid[n]),
      .out_ready(f_pop[n]),
      .out_data(f_data[n]),
      .full(f_full[n]), // R5
      .empty(f_empty[n]) // R6
    );
  end

  // Who listens to which input
  for (genvar n = 0; n < SLX_LANES; n++) begin : g_use
    for (genvar k = 0; k < SLX_LANES; k++) begin : g_k
      assign users[n][k] = (sel_reg[k] == SLX_SEL_W'(n)); // R1
    end
    // Pop only when every listening lane has room, so a shared
    // source is broadcast; a slow lane stalls all of its peers
    wire blocked = |(users[n] & ~lane_open);
    assign f_pop[n] = f_valid[n] && (|users[n]) && !blocked;
  end

  // Output stage per logical lane
  for (genvar k = 0; k < SLX_LANES; k++) begin : g_lane
    assign lane_open[k] = !lane_valid_reg[k] || lane_ready[k];
    assign lane_src_data[k] = f_data[sel_reg[k]]; // R1
    assign lane_load[k] = f_pop[sel_reg[k]];
    assign lane_valid_next[k] = lane_load[k] || (lane_valid_reg[k] && !lane_ready[k]);
    // Hold a word until the link layer takes it
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        lane_valid_reg[k] <= 1'b0;
        lane_data_reg[k] <= '0;
      end else begin
        lane_valid_reg[k] <= lane_valid_next[k];
        if (lane_load[k]) lane_data_reg[k] <= lane_src_data[k]; // R1
      end
    end
  end

  // Outputs, each straight from a flop
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign lane_valid = lane_valid_reg;
  assign lane_data = lane_data_reg;

  // Checking helpers
  // Set by the first register write after reset
  logic wrote_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) wrote_reg <= 1'b0;
    else if (reg_wr) wrote_reg <= 1'b1;
  end
  // Lane 4 source word for route checking
  logic [DATA_W-1:0] src4;
  assign src4 = lane_src_data[4];
  // Any buffer moving this cycle
  logic f_move;
  assign f_move = (|f_pop) || (|(phys_valid & phys_ready));

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Reserved bits of a selector readback stay zero
  property p_rsvd_zero;
    reg_rd && !acc_kind[2] |=> reg_rdata[7:SLX_RSVD_LSB] == SLX_RSVD_VAL;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // R1
    else $error("reserved selector bits not zero");

  // Lane 4 carries the word from its selected input
  property p_route_lane4;
    lane_load[4] |=> lane_valid[4] && lane_data[4] == $past(src4);
  endproperty
  a_route_lane4: assert property (p_route_lane4) // R1
    else $error("lane 4 data not from selected input");

  // Lane 4 code from the low bits of its byte, read back later
  property p_wr_lane4;
    reg_wr && acc_kind == SLX_REG_SEL45 ##1 (reg_rd && acc_kind == SLX_REG_SEL45 && !reg_wr)
      |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2);
  endproperty
  a_wr_lane4: assert property (p_wr_lane4) // R2
    else $error("lane 4 selector readback wrong");

  // Lanes 5 and 7 take bits 5 to 3
  property p_wr_lane57;
    reg_wr && !acc_kind[2] && acc_kind[1] |=>
      ($past(acc_kind) == SLX_REG_SEL45 ? sel_reg[5] : sel_reg[7]) == $past(reg_wdata[5:3]);
  endproperty
  a_wr_lane57: assert property (p_wr_lane57) // R3
    else $error("lane 5 or 7 selector not written");

  // Lane 6 shares the byte of lane 7
  property p_wr_lane6;
    reg_wr && acc_kind == SLX_REG_SEL67 |=> sel_reg[6] == $past(reg_wdata[2:0]);
  endproperty
  a_wr_lane6: assert property (p_wr_lane6) // R4
    else $error("lane 6 selector not written");

  // Full byte reads live buffer state
  property p_full_read;
    reg_rd && acc_kind == SLX_REG_FULL |=> reg_rvalid && reg_rdata == $past(f_full);
  endproperty
  a_full_read: assert property (p_full_read) // R5
    else $error("full status readback wrong");

  // Empty byte reads live buffer state
  property p_empty_read;
    reg_rd && acc_kind == SLX_REG_EMPTY |=> reg_rvalid && reg_rdata == $past(f_empty);
  endproperty
  a_empty_read: assert property (p_empty_read) // R6
    else $error("empty status readback wrong");

  // Lanes 0, 3, 4 and 7 keep their identity codes until software writes
  property p_rst_ident;
    !wrote_reg |-> sel_reg[0] == SLX_RST_SEL[0] && sel_reg[3] == SLX_RST_SEL[3]
      && sel_reg[4] == SLX_RST_SEL[4] && sel_reg[7] == SLX_RST_SEL[7];
  endproperty
  a_rst_ident: assert property (p_rst_ident) // R7
    else $error("selectors left identity without a write");

  // A read with no traffic leaves the flags alone
  property p_read_no_side;
    reg_rd && !f_move |=> f_full == $past(f_full) && f_empty == $past(f_empty);
  endproperty
  a_read_no_side: assert property (p_read_no_side) // R8
    else $error("status read changed buffer flags");

  // A full buffer is exactly one that refuses its input
  property p_full_refuse;
    f_full == ~phys_ready;
  endproperty
  a_full_refuse: assert property (p_full_refuse) // R5
    else $error("full flag disagrees with input ready");

  // No buffer is flagged full and empty at once
  property p_full_empty_excl;
    (f_full & f_empty) == '0;
  endproperty
  a_full_empty_excl: assert property (p_full_empty_excl) // R6
    else $error("buffer flagged full and empty");

  // A stored word clears the empty bit of its input
  property p_push_clears_empty;
    (|(phys_valid & phys_ready)) |=> ($past(phys_valid & phys_ready) & f_empty) == '0;
  endproperty
  a_push_clears_empty: assert property (p_push_clears_empty) // R6
    else $error("empty bit set after a stored word");

  // Writes to status or unmapped addresses leave every selector alone
  property p_ro_write;
    reg_wr && acc_kind[2] |=> $stable(pair_byte[0]) && $stable(pair_byte[1])
      && $stable(pair_byte[2]) && $stable(pair_byte[3]);
  endproperty
  a_ro_write: assert property (p_ro_write) // R5
    else $error("read-only write changed a selector");

  // Lanes 4 and 5 on one source load together, a broadcast
  property p_shared_load;
    sel_reg[4] == sel_reg[5] |-> lane_load[4] == lane_load[5];
  endproperty
  a_shared_load: assert property (p_shared_load) // R1
    else $error("shared source not loaded in step");

  // A stalled lane keeps its word until the link layer takes it
  property p_lane1_hold;
    lane_valid[1] && !lane_ready[1] |=> lane_valid[1] && $stable(lane_data[1]);
  endproperty
  a_lane1_hold: assert property (p_lane1_hold) // R1
    else $error("stalled lane 1 word changed");

  // Lane 7 carries the word from its selected input
  property p_route_lane7;
    lane_load[7] |=> lane_valid[7] && lane_data[7] == $past(lane_src_data[7]);
  endproperty
  a_route_lane7: assert property (p_route_lane7) // R3
    else $error("lane 7 data not from selected input");

  // One read answer per read strobe, one cycle later
  property p_rvalid_pulse;
    1'b1 |=> reg_rvalid == $past(reg_rd);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) // R8
    else $error("read answer strobe out of step");

  // Main scenarios
  c_wr_then_rd: cover property (reg_wr && acc_kind == SLX_REG_SEL45 ##1 reg_rd);
  c_remap: cover property (reg_wr && acc_kind == SLX_REG_SEL67 ##1 lane_load[7]);
  c_lane4_flow: cover property (lane_valid[4] && lane_ready[4] ##1 lane_valid[4]);
  c_full: cover property (reg_rd && acc_kind == SLX_REG_FULL && (|f_full));
  c_shared: cover property (f_pop[0] && users[0][4] && users[0][0]);
endmodule

// [slx_pkg.sv]
// Purpose: Shared constants and types for the lane crossbar and status block.
// Assumes: Byte-wide configuration bank, one register per printed address.
// Notes: Selector codes are physical input numbers, 0 to 7.
// Contract
// (R1) Selector code n routes physical input n.
// (R2) Lane 4 selector low bits, resets 4.
// (R3) Lanes 5, 7 selectors bits 5:3, reset 5, 7.
// (R4) Lane 6 selector low bits, resets 6.
// (R5) Full status byte, bit per input, resets 0.
// (R6) Empty status byte, bit per input.
// (R7) Lanes 0 to 3 selectors, identity reset.
// (R8) Status reads live, no side effects.
package slx_pkg;
  // Lane counts and widths
  localparam int SLX_LANES = 8;
  localparam int SLX_SEL_W = 3;
  localparam int SLX_BYTE_W = 8;
  localparam int SLX_ADDR_W = 12;
  localparam int SLX_DATA_W = 32;
  localparam int SLX_FIFO_DEPTH = 8;
  // Register addresses
  localparam logic [11:0] SLX_OFF_SEL_0_1 = 12'h0308;
  localparam logic [11:0] SLX_OFF_SEL_2_3 = 12'h0309;
  localparam logic [11:0] SLX_OFF_SEL_4_5 = 12'h030A;
  localparam logic [11:0] SLX_OFF_SEL_6_7 = 12'h030B;
  localparam logic [11:0] SLX_OFF_FULL = 12'h030C;
  localparam logic [11:0] SLX_OFF_EMPTY = 12'h030D;
  // Field positions inside a selector register
  localparam int SLX_LO_LSB = 0;
  localparam int SLX_HI_LSB = 3;
  localparam int SLX_RSVD_LSB = 6;
  localparam logic [1:0] SLX_RSVD_VAL = 2'h0;
  // Reset values
  localparam logic [7:0] SLX_FULL_RST = 8'h00;
  localparam logic [7:0] SLX_EMPTY_RST = 8'hFF;
  localparam logic [7:0] SLX_RDATA_RST = 8'h00;
  localparam logic [2:0] SLX_RST_SEL [SLX_LANES] =
    '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  // Kind of register an address hits
  typedef enum logic [2:0] {
    SLX_REG_SEL01 = 3'b000,
    SLX_REG_SEL23 = 3'b001,
    SLX_REG_SEL45 = 3'b010,
    SLX_REG_SEL67 = 3'b011,
    SLX_REG_FULL = 3'b100,
    SLX_REG_EMPTY = 3'b101,
    SLX_REG_NONE = 3'b110
  } slx_reg_t;
  // Address decode shared by write and read paths
  function automatic slx_reg_t slx_decode(input logic [11:0] addr);
    slx_reg_t kind;
    kind = SLX_REG_NONE;
    if (addr == SLX_OFF_SEL_0_1) kind = SLX_REG_SEL01;
    if (addr == SLX_OFF_SEL_2_3) kind = SLX_REG_SEL23;
    if (addr == SLX_OFF_SEL_4_5) kind = SLX_REG_SEL45;
    if (addr == SLX_OFF_SEL_6_7) kind = SLX_REG_SEL67;
    if (addr == SLX_OFF_FULL) kind = SLX_REG_FULL;
    if (addr == SLX_OFF_EMPTY) kind = SLX_REG_EMPTY;
    return kind;
  endfunction
endpackage

// [slx_fifo.sv]
// Purpose: Per-input lane buffer with registered full and empty flags.
// Assumes: DEPTH is at least two; producer and consumer on clk_sys.
// Notes: in_ready is a flop so back-pressure leaves the block registered.
module slx_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CNT_ZERO = '0;
  localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);

  // Storage
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic full_reg;
  logic empty_reg;
  logic ready_reg;

  // Pointer step with wrap, valid for any depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == LAST) ? '0 : AW'(p + 1'b1);
  endfunction

  // Handshakes; pop only ever sees a stored word
  wire push = in_valid && ready_reg;
  wire pop = out_ready && !empty_reg;
  assign count_next = push && !pop ? (AW + 1)'(count_reg + CNT_ONE) :
                      pop && !push ? (AW + 1)'(count_reg - CNT_ONE) : count_reg;

  // Pointers, count and flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
      ready_reg <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= step(wr_ptr_reg);
      if (pop) rd_ptr_reg <= step(rd_ptr_reg);
      count_reg <= count_next;
      full_reg <= (count_next == CNT_FULL);
      empty_reg <= (count_next == CNT_ZERO);
      ready_reg <= (count_next != CNT_FULL);
    end
  end

  // Data array, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_ptr_reg] <= in_data;
  end

  assign in_ready = ready_reg;
  assign out_valid = !empty_reg;
  assign out_data = mem[rd_ptr_reg];
  assign full = full_reg;
  assign empty = empty_reg;
endmodule

// [slx_partner.sv]
// Purpose: Far-side lane source model, one word stream per physical input.
// Assumes: Words launched just after the rising edge of clk_sys.
// Notes: Idle data lines show the inverse of the last word; a reset that drops valid leaves the word as it was.
module slx_partner
  import slx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [SLX_LANES-1:0] send,
  input wire logic [SLX_LANES-1:0] phys_ready,
  output logic [SLX_LANES-1:0] phys_valid,
  output logic [SLX_LANES-1:0][SLX_DATA_W-1:0] phys_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [SLX_LANES-1:0] taken; // Handshakes seen at the edge
  logic [SLX_LANES-1:0] snd; // Send requests seen at the edge
  logic [SLX_LANES-1:0][23:0] cnt; // Words accepted per input
  initial begin
    phys_valid = '0;
    phys_data = '0;
    cnt = '0;
  end
  // Word n,k carries its input number on top so routing is visible
  always @(posedge clk_sys) begin
    taken = phys_valid & phys_ready;
    snd = send;
    #1;
    for (int n = 0; n < SLX_LANES; n++) begin
      if (taken[n]) cnt[n] = cnt[n] + 24'h00_0001;
      if (!nrst) begin
        phys_valid[n] = 1'b0;
      end else if (phys_valid[n] && !taken[n]) begin
        // Refused word is held unchanged
      end else if (snd[n]) begin
        phys_valid[n] = 1'b1;
        phys_data[n] = {8'(n), cnt[n]};
      end else if (phys_valid[n]) begin
        phys_valid[n] = 1'b0;
        phys_data[n] = ~phys_data[n];
      end
    end
  end
endmodule

// [test_serial_lane_crossbar_fifo_status.sv]
// Purpose: Self-checking bench for the lane crossbar and buffer status bytes.
// Assumes: Lane sinks always ready unless a scenario stalls one.
// Notes: Inputs change 1 ns after the rising edge.
module test_serial_lane_crossbar_fifo_status
  import slx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys;
  logic nrst;
  logic [SLX_ADDR_W-1:0] reg_addr;
  logic [SLX_BYTE_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [SLX_BYTE_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic [SLX_LANES-1:0] phys_valid;
  logic [SLX_LANES-1:0][SLX_DATA_W-1:0] phys_data;
  logic [SLX_LANES-1:0] phys_ready;
  logic [SLX_LANES-1:0] lane_valid;
  logic [SLX_LANES-1:0][SLX_DATA_W-1:0] lane_data;
  logic [SLX_LANES-1:0] lane_ready;
  logic [SLX_LANES-1:0] send; // Word requests to the source model
  int fails;
  int samples_checked;
  int cycles; // Hang guard
  slx_crossbar DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .phys_valid(phys_valid), .phys_data(phys_data),
    .phys_ready(phys_ready), .lane_valid(lane_valid), .lane_data(lane_data),
    .lane_ready(lane_ready));
  slx_partner u_src (.clk_sys(clk_sys), .nrst(nrst), .send(send),
    .phys_ready(phys_ready), .phys_valid(phys_valid), .phys_data(phys_data));
  // Free-running 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  // Ceiling well above the 190 or so cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("[ERR] %0t timeout", $time);
      stop_test;
    end
  end
  task automatic stop_test;
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  // Each access waits an edge first so strobes never toggle twice at once
  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
  endtask
  // Answer stands one cycle, looked at right after the taking edge
  task automatic reg_read(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    check(reg_rvalid === 1'b1 && reg_rdata === exp, $sformatf("read %h", a));
  endtask
  task automatic t_reset_values;
    reg_read(SLX_OFF_SEL_0_1, 8'h08);
    reg_read(SLX_OFF_SEL_2_3, 8'h1A);
    reg_read(SLX_OFF_SEL_4_5, 8'h2C);
    reg_read(SLX_OFF_SEL_6_7, 8'h3E);
    reg_read(SLX_OFF_FULL, 8'h00);
    reg_read(SLX_OFF_EMPTY, 8'hFF);
    reg_read(12'h0300, 8'h00);
  endtask
  // Every code steers one word from its input onto lane 4
  task automatic t_routing;
    logic got;
    for (int n = 0; n < SLX_LANES; n++) begin
      reg_write(SLX_OFF_SEL_4_5, {2'b00, 3'd5, 3'(n)});
      send[n] = 1'b1;
      @(posedge clk_sys);
      #1;
      send[n] = 1'b0;
      got = 1'b0;
      for (int i = 0; i < 10; i++) begin
        @(posedge clk_sys);
        #1;
        if (lane_valid[4] === 1'b1 && !got) begin
          got = 1'b1;
          check(lane_data[4][31:24] === 8'(n), "lane 4 source");
        end
      end
      check(got, "lane 4 word missing");
    end
  endtask
  // Field placement, reserved bits, read-only byte, reset in mid-run
  task automatic t_fields;
    // Write then read on back-to-back edges
    @(posedge clk_sys);
    #1;
    reg_addr = SLX_OFF_SEL_4_5;
    reg_wdata = 8'h2B;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    check(reg_rvalid === 1'b1 && reg_rdata === 8'h2B, "write then read");
    reg_write(SLX_OFF_SEL_0_1, 8'h3A);
    reg_read(SLX_OFF_SEL_0_1, 8'h3A);
    reg_write(SLX_OFF_SEL_4_5, 8'hFF);
    reg_read(SLX_OFF_SEL_4_5, 8'h3F);
    reg_write(SLX_OFF_SEL_6_7, 8'h05);
    reg_read(SLX_OFF_SEL_6_7, 8'h05);
    reg_write(SLX_OFF_FULL, 8'hFF);
    reg_read(SLX_OFF_FULL, 8'h00);
    nrst = 1'b0;
    @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    reg_read(SLX_OFF_SEL_0_1, 8'h08);
    reg_read(SLX_OFF_SEL_4_5, 8'h2C);
    reg_read(SLX_OFF_SEL_6_7, 8'h3E);
  endtask
  // Stall lane 1 until its buffer refuses, then drain it
  task automatic t_fifo;
    int words; // Words seen on lane 1 while draining
    logic [23:0] seq; // Expected sequence number of the next word
    lane_ready[1] = 1'b0;
    send[1] = 1'b1;
    repeat (14) @(posedge clk_sys);
    #1;
    check(phys_ready[1] === 1'b0, "input 1 not refused");
    reg_read(SLX_OFF_FULL, 8'h02);
    reg_read(SLX_OFF_FULL, 8'h02);
    reg_read(SLX_OFF_EMPTY, 8'hFD);
    send[1] = 1'b0;
    lane_ready[1] = 1'b1;
    // Lane held word, eight buffered and one held at the source, in order
    words = 0;
    seq = lane_data[1][23:0];
    for (int i = 0; i < 16; i++) begin
      if (lane_valid[1] === 1'b1) begin
        check(lane_data[1] === {8'h01, seq}, "lane 1 word order");
        seq = seq + 24'h00_0001;
        words++;
      end
      @(posedge clk_sys);
      #1;
    end
    check(words == 10, "lane 1 word count");
    reg_read(SLX_OFF_FULL, 8'h00);
    reg_read(SLX_OFF_EMPTY, 8'hFF);
  endtask
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    send = '0;
    lane_ready = '1;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_reset_values;
    t_routing;
    t_fields;
    t_fifo;
    stop_test;
  end
endmodule
